// ### pbs_pkg.sv
/*
  Shared definitions for the pushbutton power sequencer: timing figures and
  their cycle counts, register offsets and fields, state types, bus carrier.
  Assumes a 25 MHz system clock and an Avalon-MM register master.
*/
package pbs_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_KHZ       = 25_000;
  localparam int unsigned CW            = 28;
  localparam int unsigned T_KEY_LOW_MS  = 50;
  localparam int unsigned T_KEY_PW_MS   = 50;
  localparam int unsigned T_KEY_REL_US  = 900;
  localparam int unsigned T_PUP_HOLD_MS = 400;
  localparam int unsigned T_RST_HOLD_S  = 5;
  localparam int unsigned T_USB_MS      = 100;
  localparam int unsigned T_WAKE_US     = 900;
  localparam int unsigned T_PUP_S       = 5;
  localparam int unsigned T_PDN_S       = 1;

  localparam logic [CW-1:0] CNT_KEY_LOW  = CW'(T_KEY_LOW_MS * CLK_KHZ);
  localparam logic [CW-1:0] CNT_KEY_PW   = CW'(T_KEY_PW_MS * CLK_KHZ);
  localparam logic [CW-1:0] CNT_KEY_REL  =
    CW'((T_KEY_REL_US * CLK_KHZ + 999) / 1000);
  localparam logic [CW-1:0] CNT_PUP_HOLD = CW'(T_PUP_HOLD_MS * CLK_KHZ);
  localparam logic [CW-1:0] CNT_RST_HOLD =
    CW'(T_RST_HOLD_S * CLK_KHZ * 1000);
  localparam logic [CW-1:0] CNT_USB      = CW'(T_USB_MS * CLK_KHZ);
  localparam logic [CW-1:0] CNT_WAKE     =
    CW'((T_WAKE_US * CLK_KHZ + 999) / 1000);
  localparam logic [CW-1:0] CNT_PUP      = CW'(T_PUP_S * CLK_KHZ * 1000);
  localparam logic [CW-1:0] CNT_PDN      = CW'(T_PDN_S * CLK_KHZ * 1000);
  localparam logic [CW-1:0] CNT_MAX      = {CW{1'b1}};

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS   = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
  localparam int unsigned STAT_ST_LSB  = 0;
  localparam int unsigned STAT_BUCK    = 4;
  localparam int unsigned STAT_LDO     = 5;
  localparam int unsigned STAT_KEY     = 6;
  localparam int unsigned STAT_USB     = 7;
  localparam int unsigned IRQ_KEY_DOWN = 0;
  localparam int unsigned IRQ_KEY_UP   = 1;
  localparam int unsigned IRQ_HARD_RST = 2;
  localparam int unsigned IRQ_PWR_ON   = 3;
  localparam int unsigned IRQ_PWR_OFF  = 4;
  localparam int unsigned IRQ_W        = 5;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    power_off_state, hard_reset_state, power_up_state_a, power_up_state_b,
    power_on_state, power_down_state_a, power_down_state_b
  } pbs_phase_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } pbs_avs_req_t;

  typedef struct packed {
    pbs_phase_t       st;
    logic [1:0]       btnS;
    logic [1:0]       usbS;
    logic [1:0]       buckS;
    logic [1:0]       ldoS;
    logic [CW-1:0]    holdCnt;
    logic [CW-1:0]    relCnt;
    logic [CW-1:0]    usbCnt;
    logic [CW-1:0]    stCnt;
    logic [CW-1:0]    pwCnt;
    logic             keyLow;
    logic             buckOn;
    logic             ldoOn;
    logic             ack;
    logic [31:0]      rdata;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
  } pbs_regs_t;

endpackage

// ### pbs_sequencer.sv
/*
  Pushbutton power sequencer: state machine, regulator enables, debounced
  open-drain key status, Avalon-MM status/interrupt registers.
  Assumes all inputs synchronous to clk apart from the two-flop stages,
  and an external pull-up on the key status line.
*/
// Functional notes
// - in power-on or power-up, 50 ms key low pulls key status low
// - after minimum pulse, key status released 900 us after key rises
// - key status stays low at least 50 ms once asserted; the code releases it at once on leaving power-on or power-up
// - from hard reset or power-off, 400 ms key hold enters power-up
// - in power-on or power-up, 5 s key hold forces hard reset
// - from hard reset or power-off, 100 ms USB present enters power-up
// - power-off, an enable high for 900 us moves to power-on
// - in power-on, buck disabled within 1 us of buck enable going low
// - in power-on, LDO disabled within 1 us of LDO enable going low
// - each power-up state lasts 5 s on the internal timer
// - each power-down state lasts 1 s on the internal timer
// - power-up enables rails in selected order, second once first is good
// - key status is open-drain debounced copy of the pushbutton
`timescale 1ns/10ps
module pbs_sequencer
  import pbs_pkg::*;
#(
  parameter logic [CW-1:0] P_KEY_LOW  = CNT_KEY_LOW,
  parameter logic [CW-1:0] P_KEY_PW   = CNT_KEY_PW,
  parameter logic [CW-1:0] P_KEY_REL  = CNT_KEY_REL,
  parameter logic [CW-1:0] P_PUP_HOLD = CNT_PUP_HOLD,
  parameter logic [CW-1:0] P_RST_HOLD = CNT_RST_HOLD,
  parameter logic [CW-1:0] P_USB      = CNT_USB,
  parameter logic [CW-1:0] P_WAKE     = CNT_WAKE,
  parameter logic [CW-1:0] P_PUP      = CNT_PUP,
  parameter logic [CW-1:0] P_PDN      = CNT_PDN
) (
  input  wire logic         clk,             // 25 MHz clock
  input  wire logic         rstn,            // sync reset, active low
  input  wire logic         keyInN,          // pushbutton, low = pressed
  input  wire logic         usbPresent,      // USB bus power present
  input  wire logic         buckEnable,      // host buck enable
  input  wire logic         ldoEnable,       // host LDO enable
  input  wire logic         railOrderSelect, // 0 buck first, 1 LDO first
  input  wire logic         buckNearReg,     // buck feedback near target
  input  wire logic         ldoNearReg,      // LDO feedback near target
  output logic              buckRegEn,       // buck regulator on
  output logic              ldoRegEn,        // LDO regulator on
  output logic              keyStatusNOut,   // open-drain level, always 0
  output logic              keyStatusNOe,    // high while pulling low
  input  wire pbs_avs_req_t avsReq,          // Avalon-MM request
  output logic [31:0]       avsReadData,     // Avalon-MM read data
  output logic              avsWaitRequest,  // Avalon-MM waitrequest
  output logic              irq              // level interrupt
);

  // ----------------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------------
  pbs_regs_t        q;
  pbs_regs_t        d;
  logic             pressed;
  logic             anyEn;
  logic             inPup;
  logic             active;
  logic             req;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;

  assign pressed = ~q.btnS[1];
  assign anyEn   = q.buckS[1] | q.ldoS[1];
  assign inPup   = (q.st == power_up_state_a) || (q.st == power_up_state_b);
  assign active  = inPup || (q.st == power_on_state);
  assign req     = avsReq.read | avsReq.write;

  function automatic logic [CW-1:0] satInc(input logic [CW-1:0] v);
    return (v == CNT_MAX) ? v : v + 1'b1;
  endfunction

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    d   = q;
    ev  = '0;
    clr = '0;
    // two-flop stages; first flop feeds only the second
    d.btnS  = {q.btnS[0], keyInN};
    d.usbS  = {q.usbS[0], usbPresent};
    d.buckS = {q.buckS[0], buckEnable};
    d.ldoS  = {q.ldoS[0], ldoEnable};
    d.holdCnt = pressed ? satInc(q.holdCnt) : '0;
    d.relCnt  = pressed ? '0 : satInc(q.relCnt);
    d.usbCnt  = q.usbS[1] ? satInc(q.usbCnt) : '0;
    d.stCnt   = satInc(q.stCnt);
    d.pwCnt   = q.keyLow ? satInc(q.pwCnt) : '0;

    // equality tests fire once per press or per USB arrival, so a key still
    // held after a hard reset cannot immediately restart power-up
    unique case (q.st)
      power_off_state: begin
        if (q.holdCnt == P_PUP_HOLD) begin
          d.st = power_up_state_a;
        end else if (q.usbCnt == P_USB) begin
          d.st = power_up_state_b;
        end else if (anyEn && q.stCnt >= P_WAKE) begin
          d.st = power_on_state;
        end else if (!anyEn) begin
          d.stCnt = '0;
        end
      end
      hard_reset_state: begin
        if (q.holdCnt == P_PUP_HOLD) begin
          d.st = power_up_state_a;
        end else if (q.usbCnt == P_USB) begin
          d.st = power_up_state_b;
        end
      end
      power_up_state_a, power_up_state_b: begin
        if (q.holdCnt == P_RST_HOLD) begin
          d.st = hard_reset_state;
        end else if (q.stCnt >= P_PUP) begin
          d.st = anyEn ? power_on_state : power_down_state_b;
        end
      end
      power_on_state: begin
        if (q.holdCnt == P_RST_HOLD) begin
          d.st = hard_reset_state;
        end else if (!anyEn) begin
          d.st = power_down_state_a;
        end
      end
      power_down_state_a, power_down_state_b: begin
        if (q.stCnt >= P_PDN) begin
          d.st = power_off_state;
        end
      end
    endcase

    if (d.st != q.st) begin
      d.stCnt = '0;
      ev[IRQ_HARD_RST] = (d.st == hard_reset_state);
      ev[IRQ_PWR_ON]   = (d.st == power_on_state);
      ev[IRQ_PWR_OFF]  = (d.st == power_off_state);
    end

    // regulators: host enables in power-on, sequenced start in power-up
    d.buckOn = 1'b0;
    d.ldoOn  = 1'b0;
    if (d.st == power_on_state) begin
      d.buckOn = q.buckS[1];
      d.ldoOn  = q.ldoS[1];
    end else if (d.st == power_up_state_a || d.st == power_up_state_b) begin
      d.buckOn = railOrderSelect ? ldoNearReg : 1'b1;
      d.ldoOn  = railOrderSelect ? 1'b1 : buckNearReg;
    end

    // debounced key status, only meaningful while powered
    if (!active) begin
      d.keyLow = 1'b0;
    end else if (!q.keyLow && q.holdCnt >= P_KEY_LOW) begin
      d.keyLow = 1'b1;
    end else if (q.keyLow && q.pwCnt >= P_KEY_PW
                 && q.relCnt >= P_KEY_REL) begin
      d.keyLow = 1'b0;
    end
    ev[IRQ_KEY_DOWN] = d.keyLow & ~q.keyLow;
    ev[IRQ_KEY_UP]   = q.keyLow & ~d.keyLow;

    // ----------------------------------------------------------------------
    // register bus: one wait cycle, then the answer
    // ----------------------------------------------------------------------
    d.ack = req & ~q.ack;
    if (req && !q.ack) begin
      d.rdata = '0;
      unique case (avsReq.address)
        ADDR_STATUS: begin
          d.rdata[STAT_ST_LSB +: 3] = q.st;
          d.rdata[STAT_BUCK]        = q.buckOn;
          d.rdata[STAT_LDO]         = q.ldoOn;
          d.rdata[STAT_KEY]         = q.keyLow;
          d.rdata[STAT_USB]         = q.usbS[1];
        end
        ADDR_IRQ_STAT: d.rdata[IRQ_W-1:0] = q.irqStat;
        ADDR_IRQ_MASK: d.rdata[IRQ_W-1:0] = q.irqMask;
        default:       d.rdata = '0;
      endcase
    end
    if (req && q.ack && avsReq.write && avsReq.byteenable[0]) begin
      if (avsReq.address == ADDR_IRQ_STAT) begin
        clr = avsReq.writedata[IRQ_W-1:0];
      end
      if (avsReq.address == ADDR_IRQ_MASK) begin
        d.irqMask = avsReq.writedata[IRQ_W-1:0];
      end
    end
    // a new event wins over a clear in the same cycle
    d.irqStat = (q.irqStat & ~clr) | ev;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      q         <= '0;
      q.st      <= power_off_state;
      q.btnS    <= 2'h3;
      q.irqMask <= IRQ_MASK_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign buckRegEn      = q.buckOn;
  assign ldoRegEn       = q.ldoOn;
  assign keyStatusNOut  = 1'b0;
  assign keyStatusNOe   = q.keyLow;
  assign avsReadData    = q.rdata;
  assign avsWaitRequest = req & ~q.ack;
  assign irq            = |(q.irqStat & q.irqMask);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_reset_off_state:
    assert property (@(posedge clk) !rstn |=> q.st == power_off_state
      && !buckRegEn && !ldoRegEn && !keyStatusNOe)
    else $error("state after reset is not power-off with outputs idle");

  chk_buck_disable:
    assert property (@(posedge clk) disable iff (!rstn)
      (q.st == power_on_state && !buckEnable) [*4] |-> !buckRegEn)
    else $error("buck still on after its enable went low");

  chk_ldo_disable:
    assert property (@(posedge clk) disable iff (!rstn)
      (q.st == power_on_state && !ldoEnable) [*4] |-> !ldoRegEn)
    else $error("ldo still on after its enable went low");

  chk_rail_order:
    assert property (@(posedge clk) disable iff (!rstn)
      inPup && !$past(railOrderSelect)
        |-> buckRegEn && (ldoRegEn == $past(buckNearReg)))
    else $error("power-up rail order wrong");

  chk_rail_order_ldo:
    assert property (@(posedge clk) disable iff (!rstn)
      inPup && $past(railOrderSelect)
        |-> ldoRegEn && (buckRegEn == $past(ldoNearReg)))
    else $error("power-up rail order wrong with LDO first");

  chk_key_assert:
    assert property (@(posedge clk) disable iff (!rstn)
      active && !q.keyLow && q.holdCnt == P_KEY_LOW
        ##1 active |-> keyStatusNOe)
    else $error("key status not pulled low after hold time");

  chk_key_pulse_width:
    assert property (@(posedge clk) disable iff (!rstn)
      $fell(keyStatusNOe) && $past(active) |-> $past(q.pwCnt) >= P_KEY_PW)
    else $error("key status pulse shorter than minimum");

  chk_key_release:
    assert property (@(posedge clk) disable iff (!rstn)
      $fell(keyStatusNOe) && $past(active) |-> $past(q.relCnt) >= P_KEY_REL)
    else $error("key status released before release delay");

  chk_hard_reset_hold:
    assert property (@(posedge clk) disable iff (!rstn)
      active && q.holdCnt == P_RST_HOLD |=> q.st == hard_reset_state)
    else $error("long key hold did not force hard reset");

  chk_pup_on_key:
    assert property (@(posedge clk) disable iff (!rstn)
      (q.st == power_off_state || q.st == hard_reset_state)
        && q.holdCnt == P_PUP_HOLD |=> q.st == power_up_state_a)
    else $error("key hold did not start power-up");

  chk_pup_on_usb:
    assert property (@(posedge clk) disable iff (!rstn)
      (q.st == power_off_state || q.st == hard_reset_state)
        && q.usbCnt == P_USB && q.holdCnt != P_PUP_HOLD
        |=> q.st == power_up_state_b)
    else $error("usb arrival did not start power-up");

  chk_pup_duration:
    assert property (@(posedge clk) disable iff (!rstn)
      $past(inPup) && !inPup && q.st != hard_reset_state
        |-> $past(q.stCnt) >= P_PUP)
    else $error("power-up state left early");

  chk_pdn_duration:
    assert property (@(posedge clk) disable iff (!rstn)
      $past(q.st) inside {power_down_state_a, power_down_state_b}
        && q.st == power_off_state |-> $past(q.stCnt) >= P_PDN)
    else $error("power-down state left early");

  chk_enable_wakeup:
    assert property (@(posedge clk) disable iff (!rstn)
      $past(q.st) == power_off_state && q.st == power_on_state
        |-> $past(q.stCnt) >= P_WAKE)
    else $error("power-on entered before enable delay");

endmodule

// ### pbs_partner.sv
/*
  Far-side model: pushbutton switch, host enables, regulator feedback.
  Assumes the bench calls its tasks just after a rising clock edge.
*/
`timescale 1ns/10ps
module pbs_partner #(
  parameter int RAMP = 12
) (
  input  wire logic clk,         // system clock
  input  wire logic buckRegEn,   // buck regulator on
  input  wire logic ldoRegEn,    // LDO regulator on
  output logic      keyInN,      // pushbutton, low = pressed
  output logic      buckEnable,  // host buck enable
  output logic      ldoEnable,   // host LDO enable
  output logic      buckNearReg, // buck near target
  output logic      ldoNearReg   // LDO near target
);
  int buckAge = 0;
  int ldoAge = 0;

  // host never leaves its enables floating
  initial begin
    keyInN = 1'h1;
    buckEnable = 1'h0;
    ldoEnable = 1'h0;
  end

  // feedback needs a soft-start ramp, drops at once when the rail is off
  always @(posedge clk) begin
    buckAge <= buckRegEn ? buckAge + 1 : 0;
    ldoAge <= ldoRegEn ? ldoAge + 1 : 0;
  end
  assign buckNearReg = buckAge >= RAMP;
  assign ldoNearReg = ldoAge >= RAMP;

  task automatic press(input logic v);
    keyInN <= ~v;
  endtask

  task automatic host(input logic b, input logic l);
    buckEnable <= b;
    ldoEnable <= l;
  endtask
endmodule

// ### pbs_sequencer_bench.sv
/*
  Self-checking bench for the pushbutton power sequencer.
  Assumes pbs_pkg, pbs_sequencer and pbs_partner compiled before it.
*/
`timescale 1ns/10ps
module pbs_sequencer_bench
  import pbs_pkg::*;
;
  // ----------------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------------
  localparam int KL = 10, KPW = 10, KR = 5, PH = 40, HOLDRST = 200;
  localparam int USB = 20, WAKE = 5, PUP = 100, PDN = 30, RAMP = 12;
  logic         clk;
  logic         rstn;
  logic         usbPresent;
  logic         railOrderSelect;
  pbs_avs_req_t avsReq;
  logic [31:0]  avsReadData;
  logic         avsWaitRequest, irq, buckRegEn, ldoRegEn;
  logic         keyStatusNOut, keyStatusNOe, keyInN;
  logic         buckEnable, ldoEnable, buckNearReg, ldoNearReg;
  int           errTotal = 0;
  int           cmpCount = 0;
  int           cyc = 0;
  logic [3:0]   beSel = 4'hF;
  // open-drain line with its board pull-up
  wire          keyLineN = keyStatusNOe ? keyStatusNOut : 1'h1;

  pbs_sequencer #(
    .P_KEY_LOW(CW'(KL)), .P_KEY_PW(CW'(KPW)), .P_KEY_REL(CW'(KR)),
    .P_PUP_HOLD(CW'(PH)), .P_RST_HOLD(CW'(HOLDRST)), .P_USB(CW'(USB)),
    .P_WAKE(CW'(WAKE)), .P_PUP(CW'(PUP)), .P_PDN(CW'(PDN))
  ) i_pbs_sequencer (
    .clk, .rstn, .keyInN, .usbPresent, .buckEnable, .ldoEnable,
    .railOrderSelect, .buckNearReg, .ldoNearReg, .buckRegEn, .ldoRegEn,
    .keyStatusNOut, .keyStatusNOe, .avsReq, .avsReadData,
    .avsWaitRequest, .irq
  );
  pbs_partner #(.RAMP(RAMP)) i_pbs_partner (
    .clk, .buckRegEn, .ldoRegEn, .keyInN, .buckEnable, .ldoEnable,
    .buckNearReg, .ldoNearReg
  );

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic results();
    if (errTotal == 0 && cmpCount > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmpCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic chkIn(input string nm, input int n, input int lo, hi);
    chk(nm, 32'(n >= lo && n <= hi), 32'h1);
  endtask

  task automatic busXfer(input logic wr, input logic [3:0] a,
                         input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    avsReq <= '{read: !wr, write: wr, address: a, writedata: wd,
                byteenable: beSel};
    // only the watchdog ends a wait for the slave
    do begin
      @(posedge clk);
    end while (avsWaitRequest !== 1'h0);
    rd = avsReadData;
    avsReq <= '0;
  endtask

  task automatic rdReg(input logic [3:0] a, output logic [31:0] d);
    busXfer(1'h0, a, 32'h0, d);
  endtask

  task automatic wrReg(input logic [3:0] a, input logic [31:0] v);
    logic [31:0] d;
    busXfer(1'h1, a, v, d);
  endtask

  task automatic waitSt(input pbs_phase_t e, input int lim, output int n);
    logic [31:0] d;
    int t0;
    t0 = cyc;
    do rdReg(ADDR_STATUS, d);
    while (d[2:0] !== e && cyc - t0 < lim);
    n = cyc - t0;
  endtask

  function automatic logic outSel(input int w);
    return w == 0 ? buckRegEn : w == 1 ? ldoRegEn : keyLineN;
  endfunction

  task automatic waitOut(input int w, input logic v, input int lim,
                         output int n);
    n = 0;
    while (outSel(w) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic doReset(input logic order);
    @(posedge clk);
    rstn <= 1'h0;
    railOrderSelect <= order;
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic tReset();
    logic [31:0] d;
    chk("buckRegEn", buckRegEn, 1'h0);
    chk("ldoRegEn", ldoRegEn, 1'h0);
    chk("key line", keyLineN, 1'h1);
    chk("open-drain data", keyStatusNOut, 1'h0);
    rdReg(ADDR_STATUS, d);
    chk("status", d, 32'h0);
    rdReg(ADDR_IRQ_MASK, d);
    chk("mask", d, 32'(IRQ_MASK_RST));
    rdReg(4'hC, d);
    chk("unmapped", d, 32'h0);
  endtask

  task automatic tBusEdge();
    logic [31:0] d;
    beSel = 4'hE;
    wrReg(ADDR_IRQ_MASK, 32'h1F);
    beSel = 4'hF;
    rdReg(ADDR_IRQ_MASK, d);
    chk("mask lane 0 off", d, 32'h0);
    wrReg(ADDR_IRQ_MASK, 32'hFFFF_FFE3);
    rdReg(ADDR_IRQ_MASK, d);
    chk("mask wide write", d, 32'h3);
    wrReg(ADDR_STATUS, 32'hFFFF_FFFF);
    wrReg(4'h5, 32'hFFFF_FFFF);
    rdReg(ADDR_STATUS, d);
    chk("status read-only", d, 32'h0);
    rdReg(4'h5, d);
    chk("unmapped odd", d, 32'h0);
  endtask

  task automatic tKeyOn();
    logic [31:0] d;
    int n, tUp;
    wrReg(ADDR_IRQ_MASK, 32'h1F);
    i_pbs_partner.press(1'h1);
    waitOut(0, 1'h1, PH + 20, n);
    tUp = cyc;
    chkIn("hold to power-up", n, PH, PH + 6);
    chk("second rail early", ldoRegEn, 1'h0);
    repeat (RAMP + 4) @(posedge clk);
    chk("second rail", ldoRegEn, 1'h1);
    chk("key line", keyLineN, 1'h0);
    chk("irq", irq, 1'h1);
    i_pbs_partner.press(1'h0);
    i_pbs_partner.host(1'h1, 1'h0);
    waitSt(power_on_state, PUP + 20, n);
    chkIn("power-up length", cyc - tUp, PUP, PUP + 8);
    wrReg(ADDR_IRQ_STAT, 32'h1F);
    rdReg(ADDR_IRQ_STAT, d);
    chk("events cleared", d, 32'h0);
    chk("irq low", irq, 1'h0);
  endtask

  task automatic tPulse();
    int n;
    @(posedge clk);
    i_pbs_partner.press(1'h1);
    waitOut(2, 1'h0, KL + 20, n);
    chkIn("key low to status", n, KL, KL + 5);
    i_pbs_partner.press(1'h0);
    waitOut(2, 1'h1, KPW + KR + 20, n);
    chkIn("status pulse width", n, KPW - 2, KPW + KR + 6);
    repeat (4) @(posedge clk);
    i_pbs_partner.press(1'h1);
    waitOut(2, 1'h0, KL + 20, n);
    repeat (KPW + 10) @(posedge clk);
    i_pbs_partner.press(1'h0);
    waitOut(2, 1'h1, KR + 20, n);
    chkIn("release delay", n, KR, KR + 6);
  endtask

  task automatic tHardReset();
    logic [31:0] d;
    int n;
    @(posedge clk);
    i_pbs_partner.press(1'h1);
    waitSt(hard_reset_state, HOLDRST + 40, n);
    chkIn("hold to hard reset", n, HOLDRST, HOLDRST + 10);
    rdReg(ADDR_IRQ_STAT, d);
    chk("hard reset event", d[IRQ_HARD_RST], 1'h1);
    wrReg(ADDR_IRQ_STAT, 32'(1 << IRQ_HARD_RST));
    rdReg(ADDR_IRQ_STAT, d);
    chk("hard reset event cleared", d[IRQ_HARD_RST], 1'h0);
    wrReg(ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq masked", irq, 1'h0);
    i_pbs_partner.press(1'h0);
    i_pbs_partner.host(1'h0, 1'h0);
  endtask

  task automatic tUsbUp();
    int n, t0;
    doReset(1'h1);
    usbPresent <= 1'h1;
    waitSt(power_up_state_b, USB + 20, n);
    t0 = cyc;
    chkIn("usb to power-up", n, USB, USB + 8);
    chk("first rail", {buckRegEn, ldoRegEn}, 2'h1);
    repeat (RAMP + 4) @(posedge clk);
    chk("second rail", buckRegEn, 1'h1);
    waitSt(power_off_state, PUP + PDN + 40, n);
    chkIn("up and down", cyc - t0, PUP + PDN - 6, PUP + PDN + 6);
    usbPresent <= 1'h0;
  endtask

  task automatic tHostOn();
    int n;
    i_pbs_partner.host(1'h1, 1'h1);
    waitSt(power_on_state, WAKE + 20, n);
    chkIn("enable to power-on", n, WAKE, WAKE + 8);
    chk("both rails", {buckRegEn, ldoRegEn}, 2'h3);
    i_pbs_partner.host(1'h0, 1'h1);
    waitOut(0, 1'h0, 40, n);
    chkIn("buck off delay", n, 0, 25);
    chk("LDO kept", ldoRegEn, 1'h1);
    i_pbs_partner.host(1'h0, 1'h0);
    waitOut(1, 1'h0, 40, n);
    chkIn("LDO off delay", n, 0, 25);
    waitSt(power_off_state, PDN + 20, n);
    chkIn("power-down length", n, PDN - 4, PDN + 8);
  endtask

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    rstn = 1'h0;
    usbPresent = 1'h0;
    railOrderSelect = 1'h0;
    avsReq = '0;
    doReset(1'h0);
    tReset();
    tBusEdge();
    tKeyOn();
    tPulse();
    tHardReset();
    tUsbUp();
    tHostOn();
    results();
  end

  initial begin
    repeat (5000) @(posedge clk);
    errTotal++;
    results();
  end
endmodule
